// file: tcc_cpu_model.sv
`timescale 1ns/1ns
module tcc_cpu_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// requests from the timer and servicing switch
	input  wire logic cmp_irq,
	input  wire logic ovf_irq,
	input  wire logic service_en,
	// vector taken pulses
	output logic      cmp_ack,
	output logic      ovf_ack
);
	logic [2:0] hold_q;

	// one vector at a time; the hold spans the request's lag so a single
	// service never acknowledges twice
	always_ff @(posedge clk) begin
		if (rst) begin
			cmp_ack <= 1'b0;
			ovf_ack <= 1'b0;
			hold_q  <= 3'h0;
		end else begin
			cmp_ack <= 1'b0;
			ovf_ack <= 1'b0;
			if (hold_q != 3'h0) begin
				hold_q <= hold_q - 3'h1;
			end else if (service_en && cmp_irq) begin
				cmp_ack <= 1'b1;
				hold_q  <= 3'h4;
			end else if (service_en && ovf_irq) begin
				ovf_ack <= 1'b1;
				hold_q  <= 3'h4;
			end
		end
	end
endmodule // tcc_cpu_model

// file: tcc_pkg.sv
package tcc_pkg;
	// register indices on the plain register port
	localparam logic [2:0] ADDR_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_COUNT   = 3'h1;
	localparam logic [2:0] ADDR_COMPARE = 3'h2;
	localparam logic [2:0] ADDR_FLAGS   = 3'h3;
	localparam logic [2:0] ADDR_IRQEN   = 3'h4;
	localparam logic [2:0] ADDR_PORT    = 3'h5;
	localparam logic [2:0] ADDR_STATUS  = 3'h6;

	// control register field positions
	localparam int CTL_CS_LSB  = 0;
	localparam int CTL_WGM0    = 3;
	localparam int CTL_COM_LSB = 4;
	localparam int CTL_WGM1    = 6;
	localparam int CTL_FORCE   = 7;
	// flag / enable bit positions
	localparam int FLG_OVF = 0;
	localparam int FLG_CMP = 1;
	// port register bits
	localparam int PRT_OUT = 0;
	localparam int PRT_DIR = 1;
	// status register bit
	localparam int STS_GIE = 7;

	localparam logic [7:0] COUNT_MAX    = 8'hFF;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic [7:0] RESET_BYTE   = 8'h00;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_PWM_PC = 2'b01,
		MODE_CTC    = 2'b10,
		MODE_FAST   = 2'b11
	} tcc_mode_type;

	// one register access from the processor
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} tcc_bus_type;
endpackage

// file: tcc_timer.sv
`timescale 1ns/1ns
// Functional notes
// RULE_01: tick comes from clock_source_select; zero means no tick, counter stopped.
// RULE_02: each tick clears, increments or decrements count_value per mode.
// RULE_03: processor may read and write count_value at any time.
// RULE_04: processor write to count_value beats any clear or count.
// RULE_05: counting sequence follows the two-bit waveform_mode_select field.
// RULE_06: overflow_flag set where mode defines; usable as interrupt request.
// RULE_07: count equals compare continuously; match sets compare_flag one tick later.
// RULE_08: compare irq only when flag, enable and global enable all set.
// RULE_09: compare_flag cleared by interrupt service or by writing one.
// RULE_10: waveform uses match, mode, action, plus max and bottom indications.
// RULE_11: PWM modes double-buffer compare_value, loaded at top or bottom.
// RULE_12: buffered modes write the buffer; otherwise the active compare register.
// RULE_13: force strobe in non-PWM updates output only; no flag, no clear.
// RULE_14: count write blocks compare matches in the following tick, even stopped; code masks compare_flag and output only, mode 2 still clears.
// RULE_15: compare_output keeps its value across mode changes.
// RULE_16: compare_output_action is unbuffered; pin source switches immediately.
// RULE_17: new action governs from next match; force makes it act at once.
// RULE_18: system reset clears compare_output to zero.
// RULE_19: nonzero action drives pin from compare_output; direction bit still rules.
// RULE_20: pin override depends on action alone, not on mode.
// RULE_21: action zero leaves compare_output unchanged on match in all modes.
// RULE_22: software should set up compare_output before enabling pin output.
// RULE_23: mode 0 counts up, wraps to zero; overflow set as count becomes zero.
// RULE_24: mode 2 clears count_value on match with compare_value.
// RULE_25: mode 3 counts single-slope zero to max, then restarts.
// RULE_26: mode 1 counts dual-slope up to max and back down to zero.
// RULE_27: tick is a one-cycle enable pulse; everything runs on the system clock.
module tcc_timer (
	// clock and reset
	input  wire logic              REF_CLK,
	input  wire logic              SYS_RST,
	// register port
	input  wire tcc_pkg::tcc_bus_type BUS,
	output logic [7:0]             RDATA,
	// prescaler tick, one cycle, already selected by clock_source_select
	input  wire logic              TIMER_TICK,
	// interrupt service acknowledges for the compare and overflow vectors
	input  wire logic              CMP_IRQ_ACK,
	input  wire logic              OVF_IRQ_ACK,
	// requests and pin
	output logic                   CMP_IRQ,
	output logic                   OVF_IRQ,
	output logic                   PIN_OUT,
	output logic                   PIN_OE
);
	logic [7:0] ctl_q;
	logic [7:0] count_q;
	logic [7:0] cmp_q;
	logic [7:0] cmp_buf_q;
	logic [1:0] flags_q;
	logic [1:0] irqen_q;
	logic [1:0] port_q;
	logic       gie_q;
	logic       oc_q;
	logic       down_q;
	logic       block_q;
	logic [7:0] rdata_q;
	logic       cmp_irq_q;
	logic       ovf_irq_q;
	logic       pin_out_q;
	logic       pin_oe_q;

	tcc_pkg::tcc_mode_type mode;
	logic [1:0] action;
	logic       pwm;
	logic       tick;
	logic       wr_ctl;
	logic       wr_cnt;
	logic       match;
	logic       at_max;
	logic       at_bottom;
	logic       force_cmp;
	logic [7:0] count_d;
	logic       ovf_set;
	logic       down_d;

	assign mode   = tcc_pkg::tcc_mode_type'({ctl_q[tcc_pkg::CTL_WGM1], ctl_q[tcc_pkg::CTL_WGM0]});
	assign action = ctl_q[tcc_pkg::CTL_COM_LSB +: 2];
	assign pwm    = (mode == tcc_pkg::MODE_PWM_PC) || (mode == tcc_pkg::MODE_FAST);
	// a zero clock source gates every tick away
	assign tick   = TIMER_TICK && (ctl_q[tcc_pkg::CTL_CS_LSB +: 3] != 3'h0); // RULE_01 RULE_27
	assign wr_ctl = BUS.wr && (BUS.addr == tcc_pkg::ADDR_CONTROL);
	assign wr_cnt = BUS.wr && (BUS.addr == tcc_pkg::ADDR_COUNT);
	assign at_max    = (count_q == tcc_pkg::COUNT_MAX);    // RULE_10
	assign at_bottom = (count_q == tcc_pkg::COUNT_BOTTOM); // RULE_10
	// comparator is live always, but a count write masks the next tick
	assign match  = (count_q == cmp_q) && !block_q; // RULE_07 RULE_14
	// force obeys the mode carried by the same write, as it does the action bits;
	// both pwm codes have the low mode bit set, and the strobe is never stored
	assign force_cmp = wr_ctl && BUS.wdata[tcc_pkg::CTL_FORCE] // RULE_13
		&& !BUS.wdata[tcc_pkg::CTL_WGM0];

	// next count and overflow point per mode
	always_comb begin
		count_d = count_q;
		ovf_set = 1'b0;
		down_d  = down_q;
		unique case (mode) // RULE_05
			tcc_pkg::MODE_NORMAL: begin
				count_d = count_q + 8'h01; // RULE_23
				ovf_set = at_max;          // RULE_23
			end
			tcc_pkg::MODE_CTC: begin
				count_d = (count_q == cmp_q) ? tcc_pkg::COUNT_BOTTOM : count_q + 8'h01; // RULE_24
				ovf_set = at_max;
			end
			tcc_pkg::MODE_FAST: begin
				count_d = at_max ? tcc_pkg::COUNT_BOTTOM : count_q + 8'h01; // RULE_25
				ovf_set = at_max;
			end
			tcc_pkg::MODE_PWM_PC: begin
				// turn round at max and at bottom; overflow at bottom
				if (at_max) begin
					down_d = 1'b1; // RULE_26
				end else if (at_bottom) begin
					down_d = 1'b0; // RULE_26
				end
				count_d = down_d ? count_q - 8'h01 : count_q + 8'h01; // RULE_02
				ovf_set = at_bottom && down_q;
			end
		endcase
	end

	// counter; processor write wins over the tick
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			count_q <= tcc_pkg::RESET_BYTE;
			down_q  <= 1'b0;
		end else if (wr_cnt) begin
			count_q <= BUS.wdata; // RULE_03 RULE_04
		end else if (tick) begin
			count_q <= count_d; // RULE_02
			down_q  <= down_d;
		end
	end

	// block flag lives until the next tick has passed, even while stopped
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			block_q <= 1'b0;
		end else if (wr_cnt) begin
			block_q <= 1'b1; // RULE_14
		end else if (tick) begin
			block_q <= 1'b0;
		end
	end

	// control, enables, port and global enable registers
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			ctl_q   <= tcc_pkg::RESET_BYTE;
			irqen_q <= 2'h0;
			port_q  <= 2'h0;
			gie_q   <= 1'b0;
		end else if (BUS.wr) begin
			if (BUS.addr == tcc_pkg::ADDR_CONTROL) begin
				ctl_q <= {1'b0, BUS.wdata[6:0]}; // RULE_16
			end
			if (BUS.addr == tcc_pkg::ADDR_IRQEN) begin
				irqen_q <= BUS.wdata[1:0];
			end
			if (BUS.addr == tcc_pkg::ADDR_PORT) begin
				port_q <= BUS.wdata[1:0];
			end
			if (BUS.addr == tcc_pkg::ADDR_STATUS) begin
				gie_q <= BUS.wdata[tcc_pkg::STS_GIE];
			end
		end
	end

	// compare register; buffered in pwm modes, updated at top (max) in both
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			cmp_q     <= tcc_pkg::RESET_BYTE;
			cmp_buf_q <= tcc_pkg::RESET_BYTE;
		end else begin
			if (BUS.wr && BUS.addr == tcc_pkg::ADDR_COMPARE) begin
				cmp_buf_q <= BUS.wdata; // RULE_12
			end
			if (!pwm) begin
				// direct access; buffer tracks so a later mode switch is clean
				if (BUS.wr && BUS.addr == tcc_pkg::ADDR_COMPARE) begin
					cmp_q <= BUS.wdata; // RULE_11 RULE_12
				end
			end else if (tick && ((mode == tcc_pkg::MODE_FAST && at_max) ||
					(mode == tcc_pkg::MODE_PWM_PC && at_max))) begin
				cmp_q <= cmp_buf_q; // RULE_11
			end
		end
	end

	// flags: hardware set beats software clear
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			flags_q <= 2'h0;
		end else begin
			if (tick && !wr_cnt && ovf_set) begin
				flags_q[tcc_pkg::FLG_OVF] <= 1'b1; // RULE_06
			end else if (OVF_IRQ_ACK || (BUS.wr && BUS.addr == tcc_pkg::ADDR_FLAGS &&
					BUS.wdata[tcc_pkg::FLG_OVF])) begin
				flags_q[tcc_pkg::FLG_OVF] <= 1'b0;
			end
			if (tick && match) begin
				flags_q[tcc_pkg::FLG_CMP] <= 1'b1; // RULE_07
			end else if (CMP_IRQ_ACK || (BUS.wr && BUS.addr == tcc_pkg::ADDR_FLAGS &&
					BUS.wdata[tcc_pkg::FLG_CMP])) begin
				flags_q[tcc_pkg::FLG_CMP] <= 1'b0; // RULE_09
			end
		end
	end

	// waveform register: match or force applies the action; zero action holds
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			oc_q <= 1'b0; // RULE_18
		end else if (force_cmp) begin
			// force uses the action in the same write, so it acts at once
			unique case (BUS.wdata[tcc_pkg::CTL_COM_LSB +: 2]) // RULE_13 RULE_17
				2'b00: oc_q <= oc_q; // RULE_21
				2'b01: oc_q <= ~oc_q;
				2'b10: oc_q <= 1'b0;
				2'b11: oc_q <= 1'b1;
			endcase
		end else if (tick) begin
			unique case (mode) // RULE_10 RULE_15
				tcc_pkg::MODE_NORMAL, tcc_pkg::MODE_CTC: begin
					if (match) begin
						unique case (action) // RULE_17
							2'b00: oc_q <= oc_q; // RULE_21
							2'b01: oc_q <= ~oc_q;
							2'b10: oc_q <= 1'b0;
							2'b11: oc_q <= 1'b1;
						endcase
					end
				end
				tcc_pkg::MODE_FAST: begin
					// clear or set at match, the opposite at the wrap to bottom
					if (action[1] && match && cmp_q != tcc_pkg::COUNT_MAX) begin
						oc_q <= action[0]; // RULE_10
					end else if (action[1] && at_max) begin
						oc_q <= ~action[0];
					end
				end
				tcc_pkg::MODE_PWM_PC: begin
					if (action[1] && match) begin
						oc_q <= down_q ? ~action[0] : action[0]; // RULE_10
					end
				end
			endcase
		end
	end

	// registered outputs: read data, requests and pin mux
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			rdata_q   <= tcc_pkg::RESET_BYTE;
			cmp_irq_q <= 1'b0;
			ovf_irq_q <= 1'b0;
			pin_out_q <= 1'b0;
			pin_oe_q  <= 1'b0;
		end else begin
			rdata_q <= tcc_pkg::RESET_BYTE;
			if (BUS.rd) begin
				unique case (BUS.addr)
					tcc_pkg::ADDR_CONTROL: rdata_q <= ctl_q;
					tcc_pkg::ADDR_COUNT:   rdata_q <= count_q; // RULE_03
					tcc_pkg::ADDR_COMPARE: rdata_q <= pwm ? cmp_buf_q : cmp_q; // RULE_12
					tcc_pkg::ADDR_FLAGS:   rdata_q <= {6'h00, flags_q};
					tcc_pkg::ADDR_IRQEN:   rdata_q <= {6'h00, irqen_q};
					tcc_pkg::ADDR_PORT:    rdata_q <= {5'h00, oc_q, port_q};
					tcc_pkg::ADDR_STATUS:  rdata_q <= {gie_q, 7'h00};
					default:               rdata_q <= tcc_pkg::RESET_BYTE;
				endcase
			end
			cmp_irq_q <= flags_q[tcc_pkg::FLG_CMP] && irqen_q[tcc_pkg::FLG_CMP] && gie_q; // RULE_08
			ovf_irq_q <= flags_q[tcc_pkg::FLG_OVF] && irqen_q[tcc_pkg::FLG_OVF] && gie_q; // RULE_06
			// override follows the action bits only, whatever the mode
			pin_out_q <= (action != 2'b00) ? oc_q : port_q[tcc_pkg::PRT_OUT]; // RULE_19 RULE_20
			pin_oe_q  <= port_q[tcc_pkg::PRT_DIR]; // RULE_19 RULE_22
		end
	end

	assign RDATA   = rdata_q;
	assign CMP_IRQ = cmp_irq_q;
	assign OVF_IRQ = ovf_irq_q;
	assign PIN_OUT = pin_out_q;
	assign PIN_OE  = pin_oe_q;

	// assertions
	property p_count_write;
		@(posedge REF_CLK) disable iff (SYS_RST)
		wr_cnt |=> count_q == $past(BUS.wdata);
	endproperty
	a_count_write: assert property (p_count_write) else $error("count write lost"); // RULE_04

	property p_stopped;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(ctl_q[2:0] == 3'h0 && !wr_cnt) |=> $stable(count_q);
	endproperty
	a_stopped: assert property (p_stopped) else $error("count moved while stopped"); // RULE_01

	property p_normal_inc;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(tick && !wr_cnt && mode == tcc_pkg::MODE_NORMAL) |=> count_q == $past(count_q) + 8'h01;
	endproperty
	a_normal_inc: assert property (p_normal_inc) else $error("normal mode step wrong"); // RULE_23

	property p_ovf_wrap;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(tick && !wr_cnt && mode == tcc_pkg::MODE_NORMAL && at_max)
		|=> flags_q[tcc_pkg::FLG_OVF] && count_q == 8'h00;
	endproperty
	a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow not set at wrap"); // RULE_23

	property p_ctc_clear;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(tick && !wr_cnt && mode == tcc_pkg::MODE_CTC && count_q == cmp_q) |=> count_q == 8'h00;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("ctc did not clear"); // RULE_24

	property p_block;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(block_q && tick && count_q == cmp_q && !flags_q[tcc_pkg::FLG_CMP])
		|=> !flags_q[tcc_pkg::FLG_CMP];
	endproperty
	a_block: assert property (p_block) else $error("match not blocked"); // RULE_14

	property p_cmp_irq;
		@(posedge REF_CLK) disable iff (SYS_RST)
		CMP_IRQ |-> $past(flags_q[tcc_pkg::FLG_CMP] && irqen_q[tcc_pkg::FLG_CMP] && gie_q);
	endproperty
	a_cmp_irq: assert property (p_cmp_irq) else $error("spurious compare irq"); // RULE_08

	property p_zero_action;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(action == 2'b00 && !force_cmp) |=> $stable(oc_q);
	endproperty
	a_zero_action: assert property (p_zero_action) else $error("output moved with zero action"); // RULE_21

	property p_force_no_flag;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(force_cmp && !tick) |=> !$rose(flags_q[tcc_pkg::FLG_CMP]) && $stable(count_q);
	endproperty
	a_force_no_flag: assert property (p_force_no_flag) else $error("force set the flag"); // RULE_13

	property p_buffer_load;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(pwm && tick && at_max) |=> cmp_q == $past(cmp_buf_q);
	endproperty
	a_buffer_load: assert property (p_buffer_load) else $error("buffer not loaded"); // RULE_11

	property p_direct_cmp;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(!pwm && BUS.wr && BUS.addr == tcc_pkg::ADDR_COMPARE)
		|=> cmp_q == $past(BUS.wdata);
	endproperty
	a_direct_cmp: assert property (p_direct_cmp) else $error("direct compare write lost"); // RULE_12

	property p_pin_source;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(action != 2'b00)
		|=> PIN_OUT == $past(oc_q) && PIN_OE == $past(port_q[tcc_pkg::PRT_DIR]);
	endproperty
	a_pin_source: assert property (p_pin_source) else $error("pin not fed by waveform"); // RULE_19

	property p_pc_turn;
		@(posedge REF_CLK) disable iff (SYS_RST)
		(tick && !wr_cnt && mode == tcc_pkg::MODE_PWM_PC && at_max)
		|=> count_q == tcc_pkg::COUNT_MAX - 8'h01 && down_q;
	endproperty
	a_pc_turn: assert property (p_pc_turn) else $error("no turn at max"); // RULE_26

	c_ovf: cover property (@(posedge REF_CLK) flags_q[tcc_pkg::FLG_OVF]);
	c_cmp_irq: cover property (@(posedge REF_CLK) CMP_IRQ);
	c_fast: cover property (@(posedge REF_CLK) mode == tcc_pkg::MODE_FAST && tick && at_max);
	c_pc_down: cover property (@(posedge REF_CLK) down_q && tick && at_bottom);
	c_force: cover property (@(posedge REF_CLK) force_cmp);
endmodule // tcc_timer

// file: timer8_counter_compare_unit_tb_top.sv
`timescale 1ns/1ns
module timer8_counter_compare_unit_tb_top;
	logic                 ref_clk, sys_rst, timer_tick, service_en;
	tcc_pkg::tcc_bus_type bus;
	logic [7:0]           rdata;
	logic                 cmp_ack, ovf_ack, cmp_irq, ovf_irq, pin_out, pin_oe;
	int                   err_count, comparisons;

	tcc_timer uut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .BUS(bus), .RDATA(rdata),
		.TIMER_TICK(timer_tick), .CMP_IRQ_ACK(cmp_ack), .OVF_IRQ_ACK(ovf_ack),
		.CMP_IRQ(cmp_irq), .OVF_IRQ(ovf_irq), .PIN_OUT(pin_out), .PIN_OE(pin_oe));
	tcc_cpu_model cpu (.clk(ref_clk), .rst(sys_rst), .cmp_irq(cmp_irq), .ovf_irq(ovf_irq),
		.service_en(service_en), .cmp_ack(cmp_ack), .ovf_ack(ovf_ack));

	// 125 MHz
	always #4 ref_clk = ~ref_clk;

	task automatic end_of_test;
		if (err_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// optional tick in the same cycle as the write, to collide with counting
	task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic tk = 1'b0);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		timer_tick <= tk;
		@(posedge ref_clk);
		bus.wr <= 1'b0;
		timer_tick <= 1'b0;
		@(posedge ref_clk);
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		@(negedge ref_clk);
		chk(rdata & m, e);
		@(posedge ref_clk);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			timer_tick <= 1'b1;
			@(posedge ref_clk);
			timer_tick <= 1'b0;
			@(posedge ref_clk);
		end
	endtask

	// outputs lag state by a cycle, so settle first
	task automatic pins_chk(input logic [7:0] e);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({4'h0, ovf_irq, cmp_irq, pin_oe, pin_out}, e);
		@(posedge ref_clk);
	endtask

	task automatic t_stopped;
		rd_chk(tcc_pkg::ADDR_PORT, 8'h07, 8'h00);
		wr(tcc_pkg::ADDR_COUNT, 8'h55);
		ticks(3);
		rd_chk(tcc_pkg::ADDR_COUNT, 8'hFF, 8'h55);
		wr(tcc_pkg::ADDR_CONTROL, 8'h01);
		wr(tcc_pkg::ADDR_COUNT, 8'h1F, 1'b1);
		rd_chk(tcc_pkg::ADDR_COUNT, 8'hFF, 8'h1F);
	endtask

	task automatic t_normal;
		wr(tcc_pkg::ADDR_COUNT, 8'hFE);
		ticks(2);
		rd_chk(tcc_pkg::ADDR_COUNT, 8'hFF, 8'h00);
		rd_chk(tcc_pkg::ADDR_FLAGS, 8'h01, 8'h01);
		wr(tcc_pkg::ADDR_FLAGS, 8'h03);
		rd_chk(tcc_pkg::ADDR_FLAGS, 8'h03, 8'h00);
		// a count write equal to compare must not flag
		wr(tcc_pkg::ADDR_COMPARE, 8'h20);
		wr(tcc_pkg::ADDR_COUNT, 8'h20);
		ticks(1);
		rd_chk(tcc_pkg::ADDR_FLAGS, 8'h02, 8'h00);
		rd_chk(tcc_pkg::ADDR_COUNT, 8'hFF, 8'h21);
	endtask

	task automatic t_irq;
		wr(tcc_pkg::ADDR_COMPARE, 8'h10);
		wr(tcc_pkg::ADDR_COUNT, 8'h0E);
		ticks(3);
		rd_chk(tcc_pkg::ADDR_FLAGS, 8'h02, 8'h02);
		wr(tcc_pkg::ADDR_IRQEN, 8'h02);
		pins_chk(8'h00);
		wr(tcc_pkg::ADDR_STATUS, 8'h80);
		pins_chk(8'h04);
		service_en <= 1'b1;
		pins_chk(8'h00);
		rd_chk(tcc_pkg::ADDR_FLAGS, 8'h02, 8'h00);
		service_en <= 1'b0;
		// overflow request and its service, with only the overflow enable set
		wr(tcc_pkg::ADDR_IRQEN, 8'h01);
		wr(tcc_pkg::ADDR_COUNT, 8'hFF);
		ticks(1);
		pins_chk(8'h08);
		service_en <= 1'b1;
		pins_chk(8'h00);
		rd_chk(tcc_pkg::ADDR_FLAGS, 8'h01, 8'h00);
		service_en <= 1'b0;
		wr(tcc_pkg::ADDR_STATUS, 8'h00);
	endtask

	task automatic t_modes;
		wr(tcc_pkg::ADDR_CONTROL, 8'h41);
		wr(tcc_pkg::ADDR_COMPARE, 8'h03);
		wr(tcc_pkg::ADDR_COUNT, 8'h00);
		wr(tcc_pkg::ADDR_FLAGS, 8'h03);
		ticks(5);
		rd_chk(tcc_pkg::ADDR_COUNT, 8'hFF, 8'h01);
		rd_chk(tcc_pkg::ADDR_FLAGS, 8'h02, 8'h02);
		rd_chk(tcc_pkg::ADDR_PORT, 8'h04, 8'h00);
		// fast PWM: new compare waits in the buffer, old value still matches
		wr(tcc_pkg::ADDR_CONTROL, 8'h69); // non-inverting output
		wr(tcc_pkg::ADDR_COMPARE, 8'h80);
		wr(tcc_pkg::ADDR_COUNT, 8'h02);
		wr(tcc_pkg::ADDR_FLAGS, 8'h03);
		ticks(2);
		rd_chk(tcc_pkg::ADDR_FLAGS, 8'h02, 8'h02);
		wr(tcc_pkg::ADDR_COUNT, 8'hFE);
		ticks(2);
		rd_chk(tcc_pkg::ADDR_COUNT, 8'hFF, 8'h00);
		rd_chk(tcc_pkg::ADDR_PORT, 8'h04, 8'h04);
		// the buffered compare is live after the wrap: a match at the new value
		wr(tcc_pkg::ADDR_FLAGS, 8'h03);
		wr(tcc_pkg::ADDR_COUNT, 8'h7F);
		ticks(2);
		rd_chk(tcc_pkg::ADDR_FLAGS, 8'h02, 8'h02);
		rd_chk(tcc_pkg::ADDR_PORT, 8'h04, 8'h00);
		wr(tcc_pkg::ADDR_CONTROL, 8'h09);
		wr(tcc_pkg::ADDR_COUNT, 8'hFE);
		ticks(2);
		rd_chk(tcc_pkg::ADDR_COUNT, 8'hFF, 8'hFE);
	endtask

	task automatic t_output;
		wr(tcc_pkg::ADDR_CONTROL, 8'h00);
		wr(tcc_pkg::ADDR_FLAGS, 8'h03);
		wr(tcc_pkg::ADDR_CONTROL, 8'h90);
		rd_chk(tcc_pkg::ADDR_PORT, 8'h04, 8'h04);
		rd_chk(tcc_pkg::ADDR_FLAGS, 8'h02, 8'h00);
		// output state set up before the pin is turned to drive
		wr(tcc_pkg::ADDR_PORT, 8'h02);
		pins_chk(8'h03);
		wr(tcc_pkg::ADDR_CONTROL, 8'h00);
		pins_chk(8'h02);
		wr(tcc_pkg::ADDR_CONTROL, 8'hE8);
		pins_chk(8'h03);
		rd_chk(tcc_pkg::ADDR_PORT, 8'h04, 8'h04);
	endtask

	// watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		#100000;
		err_count++;
		end_of_test();
	end

	initial begin
		ref_clk = 1'b0;
		sys_rst = 1'b1;
		timer_tick = 1'b0;
		service_en = 1'b0;
		bus = '0;
		err_count = 0;
		comparisons = 0;
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		t_stopped();
		t_normal();
		t_irq();
		t_modes();
		t_output();
		end_of_test();
	end
endmodule // timer8_counter_compare_unit_tb_top
